// *** design/crcx_pkg.sv ***
package crcx_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_POLY = 8'h08;
  localparam logic [7:0] OFS_SIZE = 8'h0C;

  // field positions
  localparam int STATUS_FLIP_BIT = 31;
  localparam int GENERIC_DATA_WIDTH_LSB = 0;
  localparam int GENERIC_DATA_WIDTH_MSB = 2;
  localparam int GENERIC_POLY_WIDTH_LSB = 16;
  localparam int GENERIC_POLY_WIDTH_MSB = 20;

  // values after reset
  localparam logic RST_FLIP = 1'h0;
  localparam logic [31:0] RST_POLY = 32'h0000_0000;
  localparam logic [2:0] RST_GENERIC_DATA_WIDTH = 3'h7;
  localparam logic [4:0] RST_GENERIC_POLY_WIDTH = 5'h1F;
  localparam logic [31:0] RST_RESULT = 32'h0000_0000;

  // fixed instruction widths, encoded as width minus one
  localparam logic [4:0] W8_CODE = 5'h07;
  localparam logic [4:0] W16_CODE = 5'h0F;
  localparam logic [4:0] W24_CODE = 5'h17;
  localparam logic [4:0] W32_CODE = 5'h1F;
  localparam logic [3:0] FIXED_NBITS = 4'h8;

  // cycle counts of the execute stage
  localparam int FIXED_CYCLES = 1;
  localparam int GEN_CYCLES = 3;

  // program space vector table
  localparam logic [21:0] VEC_BASE = 22'h3F_FFC0;
  localparam logic [21:0] VEC_WORDS = 22'h00_0040;

  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_CLR = 3'b001,
    OP_C8 = 3'b010,
    OP_C16 = 3'b011,
    OP_C24 = 3'b100,
    OP_C32 = 3'b101,
    OP_GEN = 3'b110
  } crcx_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_EXEC = 3'b010,
    ST_GEN2 = 3'b011,
    ST_GEN3 = 3'b100
  } crcx_state_e;

  typedef struct packed {
    crcx_op_e code;
    logic prog_space;
    logic byte_hi;
    logic [31:0] addr;
  } crcx_op_s;

  typedef struct packed {
    logic rd;
    logic prog_space;
    logic vector_hit;
    logic [31:0] addr;
  } crcx_mem_s;

  function automatic logic [31:0] width_mask(input logic [4:0] wcode);
    width_mask = 32'hFFFF_FFFF >> (5'h1F - wcode);
  endfunction : width_mask

  function automatic logic [7:0] bit_reverse(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      bit_reverse[i] = b[7 - i];
    end
  endfunction : bit_reverse

endpackage : crcx_pkg

// *** design/crcx_step.sv ***
`timescale 1ns/1ps
module crcx_step #(
  parameter int W = 32,
  parameter int NB = 8
) (
  // running remainder and divisor
  input wire logic [W-1:0] crc_in,
  input wire logic [W-1:0] poly,
  input wire logic [W-1:0] mask,
  input wire logic [4:0] wcode,
  // message slice, right justified
  input wire logic [NB-1:0] data,
  input wire logic [3:0] nbits,
  // updated remainder
  output logic [W-1:0] crc_out
);

  logic [W-1:0] chain [0:NB];
  logic [NB-1:0] aligned;

  // msb of the used slice moves to the top so bits go out msb first
  assign aligned = data << (4'(NB) - nbits);
  assign chain[0] = crc_in & mask;

  // one division step per message bit
  for (genvar i = 0; i < NB; i++) begin : g_bit
    logic fb;
    logic [W-1:0] shifted;
    assign fb = chain[i][wcode] ^ aligned[NB-1-i];
    assign shifted = (chain[i] << 1) & mask;
    assign chain[i+1] = (4'(i) >= nbits) ? chain[i] :
                        (fb ? (shifted ^ (poly & mask)) : shifted);
  end

  assign crc_out = chain[NB];

endmodule : crcx_step

// *** design/crcx_unit.sv ***
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module crcx_unit #(
  parameter logic [31:0] POLY8 = 32'h0000_0007,
  parameter logic [31:0] POLY16 = 32'h0000_1021,
  parameter logic [31:0] POLY24 = 32'h005D_6DCB,
  parameter logic [31:0] POLY32 = 32'h04C1_1DB7,
  parameter int PROG_AW = 22
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // instruction issue from the host pipeline
  input wire logic op_valid,
  input wire crcx_pkg::crcx_op_s op,
  output logic op_busy,
  output logic op_done,
  // operand fetch
  output crcx_pkg::crcx_mem_s mem_req,
  input wire logic [15:0] mem_rdata,
  // running result
  output logic [31:0] crc_result
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  crcx_pkg::crcx_state_e state_q, state_d;
  crcx_pkg::crcx_op_s op_q;
  crcx_pkg::crcx_mem_s mem_q;
  logic flip_q;
  logic [31:0] poly_q;
  logic [2:0] generic_data_width_q;
  logic [4:0] generic_poly_width_q;
  logic [31:0] result_q, result_d;
  logic [31:0] pend_q;
  logic [31:0] rdata_q, rdata_d;
  logic done_q, done_d;

  ////////////////////////////////////////////////////////////////////////////
  // issue decode

  wire idle = (state_q == crcx_pkg::ST_IDLE);
  // only crc opcodes start a fetch; clear zeroes the result, nop and code 7 leave the host alone
  wire is_crc_op = (op.code != crcx_pkg::OP_NOP) && (op.code != crcx_pkg::OP_CLR)
                   && (op.code <= crcx_pkg::OP_GEN);
  // issue while busy is dropped: the host keeps the delay slots
  wire take_fetch = op_valid && idle && is_crc_op;
  wire take_clr = op_valid && idle && (op.code == crcx_pkg::OP_CLR);

  // program addresses are 22 bits, data addresses 32 bits
  wire [31:0] fetch_addr = op.prog_space ? {{(32-PROG_AW){1'b0}}, op.addr[PROG_AW-1:0]}
                                         : op.addr;
  // vector table reads are passed unchanged and only flagged
  wire vec_hit = op.prog_space && (fetch_addr[21:0] >= crcx_pkg::VEC_BASE)
                 && ((fetch_addr[21:0] - crcx_pkg::VEC_BASE) < crcx_pkg::VEC_WORDS);

  ////////////////////////////////////////////////////////////////////////////
  // operand selection

  wire is_gen = (op_q.code == crcx_pkg::OP_GEN);
  wire [7:0] raw_byte = op_q.byte_hi ? mem_rdata[15:8] : mem_rdata[7:0];
  // msb first when clear, reversed byte when set
  wire [7:0] msg_byte = flip_q ? crcx_pkg::bit_reverse(raw_byte) : raw_byte;
  // generic width is data size field plus one
  wire [3:0] nbits = is_gen ? ({1'b0, generic_data_width_q} + 4'h1) : crcx_pkg::FIXED_NBITS;

  logic [4:0] wcode;
  logic [31:0] poly_sel;

  always_comb begin
    case (op_q.code)
      crcx_pkg::OP_C8: begin
        wcode = crcx_pkg::W8_CODE;
        poly_sel = POLY8;
      end
      crcx_pkg::OP_C16: begin
        wcode = crcx_pkg::W16_CODE;
        poly_sel = POLY16;
      end
      crcx_pkg::OP_C24: begin
        wcode = crcx_pkg::W24_CODE;
        poly_sel = POLY24;
      end
      crcx_pkg::OP_C32: begin
        wcode = crcx_pkg::W32_CODE;
        poly_sel = POLY32;
      end
      crcx_pkg::OP_GEN: begin
        wcode = generic_poly_width_q;
        poly_sel = poly_q;
      end
      default: begin
        wcode = crcx_pkg::W32_CODE;
        poly_sel = POLY32;
      end
    endcase
  end

  wire [31:0] wmask = crcx_pkg::width_mask(wcode);
  logic [31:0] step_out;

  // divides the selected bits into the current remainder
  crcx_step #(
    .W(32),
    .NB(8)
  ) u_step (
    .crc_in(result_q),
    .poly(poly_sel),
    .mask(wmask),
    .wcode(wcode),
    .data(msg_byte),
    .nbits(nbits),
    .crc_out(step_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_d = state_q;
    result_d = result_q;
    done_d = 1'b0;
    case (state_q)
      crcx_pkg::ST_IDLE: begin
        if (take_clr) begin
          result_d = crcx_pkg::RST_RESULT;
          done_d = 1'b1;
        end else if (take_fetch) begin
          state_d = crcx_pkg::ST_FETCH;
        end
      end
      crcx_pkg::ST_FETCH: begin
        state_d = crcx_pkg::ST_EXEC;
      end
      crcx_pkg::ST_EXEC: begin
        if (is_gen) begin
          state_d = crcx_pkg::ST_GEN2;
        end else begin
          result_d = step_out & wmask;
          done_d = 1'b1;
          state_d = crcx_pkg::ST_IDLE;
        end
      end
      crcx_pkg::ST_GEN2: begin
        state_d = crcx_pkg::ST_GEN3;
      end
      crcx_pkg::ST_GEN3: begin
        result_d = pend_q;
        done_d = 1'b1;
        state_d = crcx_pkg::ST_IDLE;
      end
      default: begin
        state_d = crcx_pkg::ST_IDLE;
      end
    endcase
  end

  // single clock shared with the host
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= crcx_pkg::ST_IDLE;
      result_q <= crcx_pkg::RST_RESULT;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      result_q <= result_d;
      done_q <= done_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      op_q <= '0;
      mem_q <= '0;
      pend_q <= '0;
    end else begin
      if (take_fetch) begin
        op_q <= op;
      end
      mem_q.rd <= take_fetch;
      if (take_fetch) begin
        mem_q.prog_space <= op.prog_space;
        mem_q.vector_hit <= vec_hit;
        mem_q.addr <= fetch_addr;
      end
      if (state_q == crcx_pkg::ST_EXEC) begin
        pend_q <= step_out & wmask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  wire wr_status = reg_wr && (reg_addr == crcx_pkg::OFS_STATUS);
  wire wr_poly = reg_wr && (reg_addr == crcx_pkg::OFS_POLY);
  wire wr_size = reg_wr && (reg_addr == crcx_pkg::OFS_SIZE);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flip_q <= crcx_pkg::RST_FLIP;
      poly_q <= crcx_pkg::RST_POLY;
      generic_data_width_q <= crcx_pkg::RST_GENERIC_DATA_WIDTH;
      generic_poly_width_q <= crcx_pkg::RST_GENERIC_POLY_WIDTH;
    end else begin
      if (wr_status) begin
        flip_q <= reg_wdata[crcx_pkg::STATUS_FLIP_BIT];
      end
      if (wr_poly) begin
        poly_q <= reg_wdata;
      end
      if (wr_size) begin
        generic_data_width_q <= reg_wdata[crcx_pkg::GENERIC_DATA_WIDTH_MSB:crcx_pkg::GENERIC_DATA_WIDTH_LSB];
        generic_poly_width_q <= reg_wdata[crcx_pkg::GENERIC_POLY_WIDTH_MSB:crcx_pkg::GENERIC_POLY_WIDTH_LSB];
      end
    end
  end

  // result read returns the value before a commit in the same cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        crcx_pkg::OFS_STATUS: rdata_d = {flip_q, 31'h0000_0000};
        crcx_pkg::OFS_RESULT: rdata_d = result_q;
        crcx_pkg::OFS_POLY: rdata_d = poly_q;
        crcx_pkg::OFS_SIZE: rdata_d = {11'h000, generic_poly_width_q, 13'h0000, generic_data_width_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = rdata_q;
  assign op_busy = !idle;
  assign op_done = done_q;
  assign mem_req = mem_q;
  assign crc_result = result_q;

endmodule : crcx_unit

// *** bench/crcx_unit_monitor.sv ***
`timescale 1ns/1ps
module crcx_unit_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched outputs and issue
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic op_valid,
  input wire crcx_pkg::crcx_op_s op,
  input wire logic op_busy,
  input wire logic op_done,
  input wire crcx_pkg::crcx_mem_s mem_req,
  input wire logic [31:0] crc_result
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire iss = op_valid && !op_busy;
  wire fix = iss && op.code inside {[crcx_pkg::OP_C8:crcx_pkg::OP_C32]};
  wire gen = iss && op.code == crcx_pkg::OP_GEN;
  wire clr = iss && op.code == crcx_pkg::OP_CLR;
  wire prd = mem_req.rd && mem_req.prog_space;
  wire bad = op_valid && !op_busy && (op.code == crcx_pkg::OP_NOP || op.code == 3'h7);
  wire rres = reg_rd && (reg_addr == crcx_pkg::OFS_RESULT);
  ////////////////////////////////////////
  a_fixed_latency: assert property (fix |=> !op_done ##1 !op_done ##1 op_done)
    else $error("fixed op timing wrong");
  a_gen_latency: assert property (gen |=> op_busy [*4] ##1 (op_done && !op_busy))
    else $error("generic op timing wrong");
  a_clear_zero: assert property (clr |=> op_done && crc_result == 32'h0)
    else $error("clear did not zero result");
  a_fetch_next: assert property ((fix || gen) |=> mem_req.rd)
    else $error("no operand fetch");
  a_prog_trunc: assert property (prd |-> mem_req.addr[31:22] == 10'h000)
    else $error("program address too wide");
  a_vector_flag: assert property (prd |-> mem_req.vector_hit == (mem_req.addr >= 32'h3F_FFC0))
    else $error("vector flag wrong");
  a_result_hold: assert property ($changed(crc_result) |-> op_done)
    else $error("result changed without commit");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_read_order: assert property (rres |=> reg_rdata == $past(crc_result))
    else $error("result read out of order");
  a_refused_drop: assert property (bad |=> !op_busy && !op_done && !mem_req.rd)
    else $error("refused code started work");
  c_fixed: cover property (fix);
  c_gen: cover property (gen);
  c_vector: cover property (prd && mem_req.vector_hit);
endmodule : crcx_unit_monitor

bind crcx_unit crcx_unit_monitor mon_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .op_valid(op_valid), .op(op), .op_busy(op_busy),
  .op_done(op_done), .mem_req(mem_req), .crc_result(crc_result));

// *** bench/crcx_mem_model.sv ***
`timescale 1ns/1ps
module crcx_mem_model (
  // fetch port
  input wire logic sys_clk,
  input wire crcx_pkg::crcx_mem_s mem_req,
  output logic [15:0] mem_rdata
);
  initial mem_rdata = 16'h0000;
  // word one cycle after the strobe, otherwise the bus toggles
  always @(posedge sys_clk) begin
    if (mem_req.rd === 1'b1) begin
      mem_rdata <= {~mem_req.addr[7:0], mem_req.addr[7:0]};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : crcx_mem_model

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic sys_clk, rst_n, reg_wr, reg_rd, op_valid, op_busy, op_done, fl;
  logic [7:0] reg_addr, d;
  logic [15:0] mem_rdata;
  logic [31:0] reg_wdata, reg_rdata, crc_result, e, ma;
  crcx_pkg::crcx_op_s op;
  crcx_pkg::crcx_mem_s mem_req;
  int num_errors, checks;
  localparam logic [31:0] PF [4] = '{32'h07, 32'h1021, 32'h5D_6DCB, 32'h04C1_1DB7};
  crcx_unit #(.POLY8(PF[0]), .POLY16(PF[1]), .POLY24(PF[2]), .POLY32(PF[3])) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
    .op(op), .op_busy(op_busy), .op_done(op_done), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .crc_result(crc_result));
  crcx_mem_model mem_u (.sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
  // single clock for all logic
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, reg_rdata, x);
  endtask : rd
  // msb-first division of the low nb bits of d
  function automatic logic [31:0] ref_crc(input logic [31:0] c, input logic [31:0] p,
      input int w, input int nb);
    logic fb;
    for (int i = nb - 1; i >= 0; i--) begin
      fb = c[w-1] ^ d[i];
      c = (c << 1) ^ (fb ? p : 32'h0);
    end
    return c & (32'hFFFF_FFFF >> (32 - w));
  endfunction : ref_crc
  // issue one op; dbl repeats the issue while busy, which must be dropped
  task automatic step(input crcx_pkg::crcx_op_e c, input logic [31:0] p, input int w,
      input int nb, input logic ps, input logic bh, input logic [31:0] a, input logic dbl);
    int n;
    d = bh ? ~a[7:0] : a[7:0];
    if (fl) begin
      d = {<<{d}};
    end
    e = (c == crcx_pkg::OP_CLR) ? 32'h0 : ref_crc(e, p, w, nb);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op <= {c, ps, bh, a};
    @(posedge sys_clk);
    op_valid <= dbl;
    for (n = 0; n < 8; n++) begin
      #1;
      if (mem_req.rd === 1'b1) ma = mem_req.addr;
      if (op_done === 1'b1) break;
      @(posedge sys_clk);
      op_valid <= 1'b0;
    end
    if (n == 8) begin
      $display("timeout waiting for done");
      num_errors++;
      stop_test();
    end else begin
      chk("result", crc_result, e);
    end
  endtask : step
  ////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, op_valid, fl} = '0;
    {reg_addr, reg_wdata, op, e, ma, d} = '0;
    num_errors = 0;
    checks = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd("status", crcx_pkg::OFS_STATUS, 32'h0);
    rd("poly", crcx_pkg::OFS_POLY, 32'h0);
    rd("size", crcx_pkg::OFS_SIZE, 32'h001F_0007);
    rd("unmapped", 8'h10, 32'h0);
    wr(crcx_pkg::OFS_RESULT, 32'h1234_5678);
    rd("result", crcx_pkg::OFS_RESULT, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      fl = k[0];
      wr(crcx_pkg::OFS_STATUS, {fl, 31'h0});
      step(crcx_pkg::OP_CLR, 0, 32, 8, 0, 0, 0, 0);
      step(crcx_pkg::crcx_op_e'(k + 2), PF[k], 8 * (k + 1), 8, 0, 0, 32'h1234, 0);
      step(crcx_pkg::crcx_op_e'(k + 2), PF[k], 8 * (k + 1), 8, 0, 1, 32'hC5 + k, 0);
    end
    $display("fixed test done");
    wr(crcx_pkg::OFS_POLY, 32'h0000_1021);
    wr(crcx_pkg::OFS_SIZE, 32'h000F_0003);
    step(crcx_pkg::OP_GEN, 32'h1021, 16, 4, 0, 1, 32'h37, 1);
    fl = 1'b0;
    wr(crcx_pkg::OFS_STATUS, 32'h0);
    wr(crcx_pkg::OFS_SIZE, 32'h001F_0000);
    step(crcx_pkg::OP_GEN, 32'h1021, 32, 1, 0, 0, 32'h81, 0);
    $display("generic test done");
    // refused codes leave the unit idle and the result alone
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op <= {3'h7, 1'b0, 1'b0, 32'h0000_0010};
    @(posedge sys_clk);
    op <= {crcx_pkg::OP_NOP, 1'b0, 1'b0, 32'h0000_0010};
    @(posedge sys_clk);
    op_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("busy", {31'h0000_0000, op_busy}, 32'h0000_0000);
    chk("refused", crc_result, e);
    $display("refused op test done");
    step(crcx_pkg::OP_C8, PF[0], 8, 8, 1, 0, 32'hFFFF_FFC5, 0);
    chk("fetch address", ma, 32'h003F_FFC5);
    step(crcx_pkg::OP_C8, PF[0], 8, 8, 1, 0, 32'hABC0_1234, 0);
    chk("low fetch address", ma, 32'h0000_1234);
    rd("result", crcx_pkg::OFS_RESULT, e);
    $display("program space test done");
    stop_test();
  end
endmodule : tb
